/* File: verilog/aqc_acq_control.sv */
// Acquisition control top: trigger select, pre-trigger stop, store and AXI4-Lite registers
`timescale 1ns/1ps
module aqc_acq_control import aqc_pkg::*; #(
  parameter int RESULT_BITS = 16,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter
  output logic convStart,
  input wire logic [WORD_W-1:0] convData,
  input wire logic [3:0] channelNumber,
  // Trigger sources
  input wire logic externalTriggerInput,
  input wire logic pretriggerInput,
  input wire logic pacerPulse,
  // Interrupt request
  output logic irqRequest
);
  localparam int CW = $clog2(DEPTH) + 1;
  if (CW > 15) $error("DEPTH too large for the status count field");
  aqc_fifo_if #(.WIDTH(WORD_W), .CW(CW)) fifo ();
  // Pin synchronisers and falling edge detect; bit 0 external, bit 1 pre-trigger
  logic [1:0] pinIn;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] prev_reg;
  logic [1:0] fall;
  assign pinIn = {pretriggerInput, externalTriggerInput};
  for (genvar i = 0; i < 2; i++)
  begin : g_sync
    always_ff @(posedge clk)
    begin
      if (!reset_n)
      begin
        sync1_reg[i] <= 1'b1;
        sync2_reg[i] <= 1'b1;
        prev_reg[i] <= 1'b1;
      end
      else
      begin
        sync1_reg[i] <= pinIn[i];
        sync2_reg[i] <= sync1_reg[i];
        prev_reg[i] <= sync2_reg[i];
      end
    end
    assign fall[i] = prev_reg[i] && !sync2_reg[i];
  end
  // Registers
  logic [CTL_W-1:0] control_reg;
  logic [STOP_W-1:0] stopCount_reg;
  logic gate_reg;
  logic stopped_reg;
  logic swTrig_reg;
  logic halfPrev_reg;
  wire extSel = control_reg[CTL_EXT_SEL];
  wire pacerSel = control_reg[CTL_PACER_SEL];
  wire preEn = control_reg[CTL_PRE_EN];
  wire eocMode = control_reg[CTL_EOC_IRQ];
  wire halfMode = control_reg[CTL_HALF_IRQ];
  // Trigger selection
  logic busy;
  logic resultValid;
  logic [WORD_W-1:0] resultWord;
  wire internalTrig = pacerSel ? pacerPulse : swTrig_reg;
  wire rawTrig = extSel ? fall[0] : internalTrig;
  wire trigTaken = rawTrig && !stopped_reg && !busy;
  wire gateSet = preEn && fall[1] && !gate_reg && !stopped_reg;
  wire lastCount = gate_reg && trigTaken && (stopCount_reg == STOP_W'(1));
  aqc_conv_seq #(.RESULT_BITS(RESULT_BITS)) u_seq (
    .clk(clk),
    .reset_n(reset_n),
    .start(trigTaken),
    .busy(busy),
    .convStart(convStart),
    .convData(convData),
    .channel(channelNumber),
    .resultValid(resultValid),
    .resultWord(resultWord)
  );
  aqc_result_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .port(fifo.store)
  );
  // AXI4-Lite slave
  logic awHeld_reg;
  logic wHeld_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  wire awHs = s_axi_awvalid && s_axi_awready;
  wire wHs = s_axi_wvalid && s_axi_wready;
  wire arHs = s_axi_arvalid && s_axi_arready;
  wire doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  aqc_reg_e wrSel;
  aqc_reg_e rdSel;
  assign wrSel = aqcDecode(awAddr_reg);
  assign rdSel = aqcDecode(s_axi_araddr);
  wire [STOP_W-1:0] stopWrite = {wStrb_reg[1] ? wData_reg[15:8] : stopCount_reg[15:8],
    wStrb_reg[0] ? wData_reg[7:0] : stopCount_reg[7:0]};
  wire ctlWrite = doWrite && (wrSel == REG_CONTROL) && wStrb_reg[0];
  // A zero count is refused; the count is loaded only while the gate is closed
  wire stopLoad = doWrite && (wrSel == REG_STOP) && !gate_reg && (stopWrite != '0);
  logic [31:0] status;
  assign status = {(16-CW)'(0), fifo.count, 10'h000, stopped_reg, gate_reg,
    fifo.full, fifo.halfFull, !busy, !fifo.empty};
  logic [31:0] readMux;
  assign readMux = (rdSel == REG_DATA) ? (fifo.empty ? 32'h0 : {16'h0, fifo.rdData}) :
    (rdSel == REG_STATUS) ? status :
    (rdSel == REG_CONTROL) ? {27'h0, control_reg} :
    (rdSel == REG_STOP) ? {16'h0, stopCount_reg} : 32'h0;
  assign fifo.rdEn = arHs && (rdSel == REG_DATA);
  assign fifo.wrEn = resultValid;
  assign fifo.wrData = resultWord;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wStrb_reg <= '0;
    end
    else
    begin
      if (awHs)
      begin
        s_axi_awready <= 1'b0;
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      else if (!awHeld_reg && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (wHs)
      begin
        s_axi_wready <= 1'b0;
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      else if (!wHeld_reg && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (doWrite)
      begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrSel == REG_NONE || wrSel == REG_DATA ||
          wrSel == REG_STATUS) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (arHs)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readMux;
      s_axi_rresp <= (rdSel == REG_NONE || rdSel == REG_SWTRIG) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end
  // Control, pre-trigger stop counter and interrupt request
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      control_reg <= CONTROL_RESET;
      stopCount_reg <= STOP_RESET;
      gate_reg <= 1'b0;
      stopped_reg <= 1'b0;
      swTrig_reg <= 1'b0;
      halfPrev_reg <= 1'b0;
      irqRequest <= 1'b0;
    end
    else
    begin
      swTrig_reg <= doWrite && (wrSel == REG_SWTRIG);
      if (ctlWrite) control_reg <= wData_reg[CTL_W-1:0];
      if (stopLoad) stopCount_reg <= stopWrite;
      else if (gate_reg && trigTaken && !lastCount)
        stopCount_reg <= stopCount_reg - 1'b1;
      if (!preEn)
      begin
        gate_reg <= 1'b0;
        stopped_reg <= 1'b0;
      end
      else if (lastCount)
      begin
        gate_reg <= 1'b0;
        stopped_reg <= 1'b1;
      end
      else if (gateSet)
        gate_reg <= 1'b1;
      halfPrev_reg <= fifo.halfFull;
      irqRequest <= (eocMode && fifo.wrEn && !fifo.full) ||
        (halfMode && fifo.halfFull && !halfPrev_reg);
    end
  end
  ext_trigger_a: assert property (@(posedge clk) disable iff (!reset_n)
    extSel && fall[0] && !stopped_reg && !busy |=> convStart)
    else $error("external falling edge did not start a conversion");
  ext_only_a: assert property (@(posedge clk) disable iff (!reset_n)
    extSel && !fall[0] |=> !convStart)
    else $error("internal source started a conversion in external mode");
  pacer_trigger_a: assert property (@(posedge clk) disable iff (!reset_n)
    !extSel && pacerSel && pacerPulse && !busy && !stopped_reg |=> convStart)
    else $error("pacer pulse lost");
  soft_trigger_a: assert property (@(posedge clk) disable iff (!reset_n)
    !extSel && !pacerSel && swTrig_reg && !busy && !stopped_reg |=> convStart)
    else $error("software trigger lost");
  one_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    fall[0] |=> !fall[0])
    else $error("edge event longer than one cycle");
  stop_block_a: assert property (@(posedge clk) disable iff (!reset_n)
    stopped_reg && $past(stopped_reg) |-> !convStart)
    else $error("conversion after stop");
  count_down_a: assert property (@(posedge clk) disable iff (!reset_n)
    preEn && gate_reg && trigTaken && !stopLoad |=> stopCount_reg == $past(stopCount_reg) - 16'h0001
      || stopped_reg)
    else $error("stop counter failed to decrement");
  gate_open_a: assert property (@(posedge clk) disable iff (!reset_n)
    gateSet && !lastCount |=> gate_reg)
    else $error("pre-trigger edge did not open the gate");
  count_range_a: assert property (@(posedge clk) disable iff (!reset_n)
    stopCount_reg != 16'h0000)
    else $error("stop count reached zero value");
  data_present_a: assert property (@(posedge clk) disable iff (!reset_n)
    resultValid && !fifo.full |=> status[ST_DATA_PRESENT])
    else $error("result not present after write");
  eoc_irq_a: assert property (@(posedge clk) disable iff (!reset_n)
    eocMode && resultValid && !fifo.full |=> irqRequest)
    else $error("end-of-conversion request missing");
  half_irq_a: assert property (@(posedge clk) disable iff (!reset_n)
    halfMode && $rose(fifo.halfFull) |=> irqRequest)
    else $error("half-full request missing");
  empty_data_a: assert property (@(posedge clk) disable iff (!reset_n)
    arHs && rdSel == REG_DATA && fifo.empty |=> s_axi_rvalid && s_axi_rdata == 32'h0)
    else $error("empty read returned stale data");
endmodule

/* File: verilog/aqc_pkg.sv */
// Constants, register map and address decode for the acquisition control block
package aqc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned CONV_MAX_NS = 8500;
  // Longest time rounds down to whole cycles
  localparam int unsigned CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  // Result sampled two cycles early so the store write also fits
  localparam int unsigned CONV_SAMPLE_CYC = CONV_MAX_CYC - 2;
  localparam int unsigned FIFO_DEPTH = 1024;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned STOP_W = 16;
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_DATA = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_SWTRIG = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_STOP = 12'h010;
  localparam int unsigned CTL_EXT_SEL = 0;
  localparam int unsigned CTL_PACER_SEL = 1;
  localparam int unsigned CTL_PRE_EN = 2;
  localparam int unsigned CTL_EOC_IRQ = 3;
  localparam int unsigned CTL_HALF_IRQ = 4;
  localparam int unsigned CTL_W = 5;
  localparam logic [CTL_W-1:0] CONTROL_RESET = 5'h00;
  localparam logic [STOP_W-1:0] STOP_RESET = 16'h0001;
  localparam int unsigned ST_DATA_PRESENT = 0;
  localparam int unsigned ST_IDLE = 1;
  localparam int unsigned ST_HALF = 2;
  localparam int unsigned ST_FULL = 3;
  localparam int unsigned ST_GATE = 4;
  localparam int unsigned ST_STOPPED = 5;
  localparam int unsigned ST_COUNT_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum {REG_DATA, REG_STATUS, REG_CONTROL, REG_SWTRIG, REG_STOP, REG_NONE} aqc_reg_e;
  function automatic aqc_reg_e aqcDecode(input logic [ADDR_W-1:0] addr);
    unique case ({addr[ADDR_W-1:2], 2'h0})
      OFS_DATA: return REG_DATA;
      OFS_STATUS: return REG_STATUS;
      OFS_CONTROL: return REG_CONTROL;
      OFS_SWTRIG: return REG_SWTRIG;
      OFS_STOP: return REG_STOP;
      default: return REG_NONE;
    endcase
  endfunction
endpackage

/* File: verilog/aqc_fifo_if.sv */
// Write and read port of the result store
`timescale 1ns/1ps
interface aqc_fifo_if #(parameter int WIDTH = 16, parameter int CW = 11);
  logic wrEn;
  logic [WIDTH-1:0] wrData;
  logic rdEn;
  logic [WIDTH-1:0] rdData;
  logic empty;
  logic full;
  logic halfFull;
  logic [CW-1:0] count;
  modport store (input wrEn, wrData, rdEn, output rdData, empty, full, halfFull, count);
  modport user (output wrEn, wrData, rdEn, input rdData, empty, full, halfFull, count);
endinterface

/* File: verilog/aqc_result_fifo.sv */
// First-in first-out store for conversion results
`timescale 1ns/1ps
module aqc_result_fifo import aqc_pkg::*; #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 1024
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Store port
  aqc_fifo_if.store port
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
  localparam logic [PW:0] HALF_COUNT = (PW+1)'(DEPTH / 2);
  if (DEPTH < 2 || (1 << PW) != DEPTH) $error("DEPTH must be a power of two");
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [PW:0] count_reg;
  wire doWr = port.wrEn && !port.full;
  wire doRd = port.rdEn && !port.empty;
  assign port.rdData = mem[rdPtr_reg];
  assign port.empty = (count_reg == '0);
  assign port.full = (count_reg == FULL_COUNT);
  assign port.halfFull = (count_reg >= HALF_COUNT);
  assign port.count = count_reg;
  always_ff @(posedge clk)
  begin
    if (doWr) mem[wrPtr_reg] <= port.wrData;
  end
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (doWr) wrPtr_reg <= wrPtr_reg + 1'b1;
      if (doRd) rdPtr_reg <= rdPtr_reg + 1'b1;
      if (doWr && !doRd) count_reg <= count_reg + 1'b1;
      else if (doRd && !doWr) count_reg <= count_reg - 1'b1;
    end
  end
  full_no_overwrite_a: assert property (@(posedge clk) disable iff (!reset_n)
    port.full && port.wrEn && !port.rdEn |=> port.full && $stable(wrPtr_reg))
    else $error("store overwritten while full");
  empty_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    port.empty && port.rdEn && !port.wrEn |=> port.empty && $stable(rdPtr_reg))
    else $error("empty read moved the store");
endmodule

/* File: verilog/aqc_conv_seq.sv */
// Conversion sequencer: start pulse, timed sampling and result word format
`timescale 1ns/1ps
module aqc_conv_seq import aqc_pkg::*; #(
  parameter int RESULT_BITS = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic start,
  output logic busy,
  // Converter
  output logic convStart,
  input wire logic [WORD_W-1:0] convData,
  input wire logic [3:0] channel,
  // Result
  output logic resultValid,
  output logic [WORD_W-1:0] resultWord
);
  localparam int ConvDly = CONV_SAMPLE_CYC;
  localparam logic [8:0] LAST_CNT = 9'(CONV_SAMPLE_CYC - 1);
  if (RESULT_BITS != 12 && RESULT_BITS != 16) $error("RESULT_BITS must be 12 or 16");
  typedef enum {SEQ_IDLE, SEQ_CONVERT} aqc_seq_e;
  aqc_seq_e state_reg;
  logic [8:0] cnt_reg;
  logic [WORD_W-1:0] word_next;
  if (RESULT_BITS == 12)
  begin : g_low
    assign word_next = {convData[WORD_W-1:4], channel};
  end
  else
  begin : g_high
    assign word_next = convData;
  end
  assign busy = (state_reg == SEQ_CONVERT);
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_reg <= SEQ_IDLE;
      cnt_reg <= '0;
      convStart <= 1'b0;
      resultValid <= 1'b0;
      resultWord <= '0;
    end
    else
    begin
      convStart <= 1'b0;
      resultValid <= 1'b0;
      unique case (state_reg)
        SEQ_IDLE:
        begin
          if (start)
          begin
            state_reg <= SEQ_CONVERT;
            cnt_reg <= '0;
            convStart <= 1'b1;
          end
        end
        SEQ_CONVERT:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == LAST_CNT)
          begin
            state_reg <= SEQ_IDLE;
            resultValid <= 1'b1;
            resultWord <= word_next;
          end
        end
      endcase
    end
  end
  conv_time_a: assert property (@(posedge clk) disable iff (!reset_n)
    convStart |-> ##[1:ConvDly] resultValid)
    else $error("conversion overran its time");
  busy_conv_a: assert property (@(posedge clk) disable iff (!reset_n)
    convStart |-> busy ##1 busy[*8])
    else $error("idle flag high during conversion");
endmodule

/* File: verif/aqc_conv_model.sv */
// Converter model: hands back a known code for each conversion start
`timescale 1ns/1ps
module aqc_conv_model import aqc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Converter
  input wire logic convStart,
  output logic [WORD_W-1:0] convData
);
  logic [15:0] convCount;
  logic [7:0] low;
  logic [15:0] nextCode;
  assign low = convCount[7:0];
  // First two codes are the extreme positive and negative values
  assign nextCode = (convCount == 16'h0000) ? 16'h7fff :
    (convCount == 16'h0001) ? 16'h8000 : {low ^ 8'h5a, ~low};
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      convCount <= 16'h0000;
      convData <= 16'h0000;
    end
    else if (convStart)
    begin
      convCount <= convCount + 16'h0001;
      convData <= nextCode;
    end
  end
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the acquisition control block
`timescale 1ns/1ps
module testbench import aqc_pkg::*;;
  logic clk = 1'b0;
  logic reset_n;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, rdata12, rd12;
  logic [3:0] chanLog [$];
  logic [3:0] s_axi_wstrb, channelNumber;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic convStart, externalTriggerInput, pretriggerInput, pacerPulse, irqRequest;
  logic [WORD_W-1:0] convData;
  logic [7:0] rnd;
  int failures, checks, irqCount, irqBase, nRead, n;
  logic [4:0] modes [3] = '{5'h02, 5'h01, 5'h03};
  always #12.5 clk = ~clk;
  aqc_acq_control #(.RESULT_BITS(16), .DEPTH(16)) i_aqc_acq_control (.clk(clk),
    .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .convStart(convStart), .convData(convData), .channelNumber(channelNumber),
    .externalTriggerInput(externalTriggerInput), .pretriggerInput(pretriggerInput),
    .pacerPulse(pacerPulse), .irqRequest(irqRequest));
  // Same inputs as the main instance; only its read data is watched
  aqc_acq_control #(.RESULT_BITS(12), .DEPTH(16)) i_aqc_acq_control_12 (.clk(clk),
    .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(), .s_axi_rdata(rdata12), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready(s_axi_rready), .convStart(), .convData(convData),
    .channelNumber(channelNumber), .externalTriggerInput(externalTriggerInput),
    .pretriggerInput(pretriggerInput), .pacerPulse(pacerPulse), .irqRequest());
  aqc_conv_model i_aqc_conv_model (.clk(clk), .reset_n(reset_n), .convStart(convStart),
    .convData(convData));
  always @(posedge clk)
    if (reset_n === 1'b1 && irqRequest === 1'b1)
      irqCount++;
  // Channel in force for each conversion, in conversion order
  always @(posedge clk)
    if (reset_n === 1'b1 && convStart === 1'b1)
      chanLog.push_back(channelNumber);
  function automatic logic [7:0] lfsrNext(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] expData(input int k);
    logic [7:0] b;
    b = k[7:0];
    if (k == 0)
      return 32'h0000_7fff;
    if (k == 1)
      return 32'h0000_8000;
    return {16'h0000, b ^ 8'h5a, ~b};
  endfunction
  // Millivolts at unity gain with the 16-bit scale constant
  function automatic logic [31:0] toMillivolts(input logic [15:0] code);
    return 32'($signed(code) * 32'sh0000_2710 / 32'sh0000_8000);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic axiWrite(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axiRead(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rd12 = rdata12;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  // One trigger event, then long enough for the result to land
  task automatic fire(input logic ext);
    rnd = lfsrNext(rnd);
    channelNumber <= rnd[3:0];
    if (ext)
      externalTriggerInput <= 1'b0;
    else
      pacerPulse <= 1'b1;
    @(posedge clk);
    pacerPulse <= 1'b0;
    repeat (4) @(posedge clk);
    externalTriggerInput <= 1'b1;
    repeat (345 + rnd[2:0]) @(posedge clk);
  endtask
  task automatic drain(input int cnt);
    logic [31:0] want;
    repeat (cnt)
    begin
      axiRead(OFS_DATA);
      want = expData(nRead);
      check("data word", {16'h0000, rd[15:0]}, want);
      check("data 12-bit", {16'h0, rd12[15:0]}, {16'h0, want[15:4], chanLog[nRead]});
      nRead++;
    end
  endtask
  task automatic readStatus(input string what, input logic [31:0] exp);
    axiRead(OFS_STATUS);
    check(what, rd, exp);
  endtask
  initial
  begin
    repeat (40000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    summarize();
  end
  initial
  begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, channelNumber, pacerPulse} = 61'h0;
    {s_axi_wstrb, externalTriggerInput, pretriggerInput} = 6'h3f;
    {failures, checks, irqCount, nRead} = 128'h0;
    rnd = 8'h5e;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    axiRead(OFS_CONTROL);
    check("control reset", rd, 32'h0);
    axiRead(OFS_STOP);
    check("stop reset", rd, 32'h1);
    readStatus("status reset", 32'h2);
    axiRead(12'h020);
    check("unmapped read", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    axiWrite(OFS_STATUS, 32'h0);
    check("status write", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    $display("test registers done");
    axiWrite(OFS_CONTROL, 32'h08);
    irqBase = irqCount;
    axiWrite(OFS_SWTRIG, {24'h0, rnd});
    axiWrite(OFS_SWTRIG, 32'h1);
    axiRead(OFS_STATUS);
    check("idle while busy", {31'h0, rd[ST_IDLE]}, 32'h0);
    repeat (331) @(posedge clk);
    readStatus("result present", 32'h0001_0003);
    check("eoc irq", irqCount - irqBase, 1);
    drain(1);
    check("full scale mV", toMillivolts(rd[15:0]), 32'h0000_270f);
    $display("test software trigger done");
    foreach (modes[i])
    begin
      axiWrite(OFS_CONTROL, {27'h0, modes[i]});
      axiWrite(OFS_SWTRIG, 32'h1);
      fire(~modes[i][0]);
      fire(modes[i][0]);
      axiRead(OFS_STATUS);
      check("words per source", {21'h0, rd[26:16]}, 32'h1);
      drain(1);
    end
    $display("test trigger select done");
    for (int p = 0; p < 2; p++)
    begin
      rnd = lfsrNext(rnd);
      n = (p == 0) ? 1 : 2 + rnd[1:0];
      axiWrite(OFS_CONTROL, 32'h02);
      axiWrite(OFS_STOP, n);
      axiWrite(OFS_CONTROL, 32'h06);
      fire(1'b0);
      pretriggerInput <= 1'b0;
      repeat (6) @(posedge clk);
      pretriggerInput <= 1'b1;
      axiRead(OFS_STATUS);
      check("gate open", {31'h0, rd[ST_GATE]}, 32'h1);
      repeat (n + 2) fire(1'b0);
      axiRead(OFS_STATUS);
      check("words after event", {21'h0, rd[26:16]}, n + 1);
      check("stopped", {30'h0, rd[ST_STOPPED], rd[ST_GATE]}, 32'h2);
      drain(n + 1);
      axiWrite(OFS_CONTROL, 32'h02);
    end
    axiWrite(OFS_STOP, 32'h0);
    axiRead(OFS_STOP);
    check("zero load refused", rd, 32'h1);
    $display("test pre-trigger done");
    axiWrite(OFS_CONTROL, 32'h12);
    irqBase = irqCount;
    for (int i = 1; i <= 17; i++)
    begin
      fire(1'b0);
      if (i == 7 || i == 8)
      begin
        axiRead(OFS_STATUS);
        check("half flag", {31'h0, rd[ST_HALF]}, (i == 8));
        check("half irq", irqCount - irqBase, i - 7);
      end
    end
    axiRead(OFS_STATUS);
    check("full count", {21'h0, rd[26:16]}, 32'h10);
    check("full flag", {31'h0, rd[ST_FULL]}, 32'h1);
    check("single half irq", irqCount - irqBase, 1);
    drain(16);
    nRead++;
    $display("test fill done");
    readStatus("empty status", 32'h2);
    axiRead(OFS_DATA);
    check("empty read", rd, 32'h0);
    readStatus("status kept", 32'h2);
    $display("test empty read done");
    summarize();
  end
endmodule
